// *** src/periph_irq_top.sv ***
// Peripheral interrupt flag and enable block with APB register access
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pirq_map.svh"
module periph_irq_top (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  // CAN controller events
  input  wire logic          can_bad_msg_ev,
  input  wire logic          can_wake_ev,
  input  wire pirq_pkg::byte_t can_comm_status,
  input  wire logic [2:0]    can_tx_done_ev,
  input  wire logic          can_rx0_ev,
  input  wire logic          can_rx1_ev,
  input  wire logic          can_rx_any_ev,
  input  wire logic          can_fifo_half_lvl,
  input  wire logic          can_fifo_full_lvl,
  // Flags held by other peripherals, and the CAN enable register
  input  wire pirq_pkg::byte_t periph_flags_one,
  input  wire pirq_pkg::byte_t periph_flags_two,
  input  wire pirq_pkg::byte_t periph_flags_three,
  input  wire pirq_pkg::byte_t can_enable_five,
  // Requests
  output var  logic          cpu_periph_req,
  output var  logic          irq
);
  import pirq_pkg::*;

  function automatic logic hit(input byte_t a, input byte_t ofs);
    hit = (a == ofs);
  endfunction

  function automatic byte_t wmerge(input byte_t old, input byte_t nw,
                                   input byte_t msk);
    wmerge = (old & ~msk) | (nw & msk);
  endfunction

  function automatic byte_t rise(input byte_t prev, input byte_t cur);
    rise = cur & ~prev;
  endfunction

  pirq_if fb ();

  byte_t periph_irq_enable_one;
  byte_t periph_irq_enable_two;
  byte_t periph_irq_enable_three;
  byte_t ctrl;
  byte_t irq_stat;
  byte_t irq_mask;
  byte_t prev_flags;

  // APB phases; no wait state, read data registered in the setup phase so it comes from a flip-flop
  wire   setup    = psel && !penable;
  wire   access   = psel && penable && pready;
  wire   hit_flg  = hit(paddr, `OFS_CAN_FLAGS);
  wire   hit_en1  = hit(paddr, `OFS_EN_ONE);
  wire   hit_en2  = hit(paddr, `OFS_EN_TWO);
  wire   hit_en3  = hit(paddr, `OFS_EN_THREE);
  wire   hit_ctl  = hit(paddr, `OFS_CTRL);
  wire   hit_sts  = hit(paddr, `OFS_IRQ_STAT);
  wire   hit_msk  = hit(paddr, `OFS_IRQ_MASK);
  wire   hit_pnd  = hit(paddr, `OFS_PEND);
  wire   addr_ok  = hit_flg | hit_en1 | hit_en2 | hit_en3 |
                    hit_ctl | hit_sts | hit_msk | hit_pnd;
  // Byte lane 0 carries every register; other lanes are don't-care
  wire   wr_take  = access && pwrite && pstrb[0] && !pslverr;
  wire byte_t wbyte = pwdata[7:0];

  // Mode 3 is undefined; such a write keeps the old mode
  wire   bad_mode = (wbyte[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB] == 2'b11);
  wire byte_t ctrl_wdata = bad_mode ?
         {wbyte[7:`CTRL_MODE_LSB+2],
          ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB],
          wbyte[`CTRL_MODE_LSB-1:0]} : wbyte;

  wire   prio_en  = ctrl[`CTRL_PRIO_BIT];
  wire   global_periph_irq_enable     = ctrl[`CTRL_GLOBAL_PERIPH_IRQ_ENABLE_BIT];

  // Flag bank link
  assign fb.clk           = ref_clk;
  assign fb.rst           = sys_rst;
  assign fb.mode          = can_mode_e'(ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]);
  assign fb.hf_sel        = ctrl[`CTRL_HF_BIT];
  assign fb.ev_bad_msg    = can_bad_msg_ev;
  assign fb.ev_wake       = can_wake_ev;
  assign fb.comm_status   = can_comm_status;
  assign fb.ev_tx_done    = can_tx_done_ev;
  assign fb.ev_rx0        = can_rx0_ev;
  assign fb.ev_rx1        = can_rx1_ev;
  assign fb.ev_rx_any     = can_rx_any_ev;
  assign fb.fifo_half_lvl = can_fifo_half_lvl;
  assign fb.fifo_full_lvl = can_fifo_full_lvl;
  assign fb.wr_en         = wr_take && hit_flg;
  assign fb.wr_data       = wbyte;

  can_flag_bank u_bank (
    .fb (fb.bank)
  );

  // Request gating: flag and enable per source
  wire byte_t pend_can   = fb.flags & can_enable_five;
  wire byte_t pend_one   = periph_flags_one & periph_irq_enable_one;
  wire byte_t pend_two   = periph_flags_two & periph_irq_enable_two;
  wire byte_t pend_three = periph_flags_three & periph_irq_enable_three;
  wire   any_pend = |{pend_can, pend_one, pend_two, pend_three};
  // Priority scheme on hands gating to the vectoring logic downstream
  wire   next_req = any_pend && (prio_en || global_periph_irq_enable);

  wire byte_t pend_view = {3'b000, next_req, |pend_three, |pend_two,
                           |pend_one, |pend_can};

  // Sticky events: new CAN flag and a rising CPU request
  wire   can_new  = |rise(prev_flags, fb.flags);
  wire   req_rise = next_req && !cpu_periph_req;
  wire byte_t stat_set = (byte_t'(can_new) << `STAT_CAN_BIT) |
                         (byte_t'(req_rise) << `STAT_REQ_BIT);
  wire byte_t stat_clr = (wr_take && hit_sts) ?
                         (wbyte & `STAT_WMASK) : `REG_RESET;
  // Set wins over a write-one clear in the same cycle
  wire byte_t next_stat = (irq_stat & ~stat_clr) | stat_set;

  // Register read selection
  wire byte_t rd_byte =
      hit_flg ? fb.flags :
      hit_en1 ? periph_irq_enable_one :
      hit_en2 ? periph_irq_enable_two :
      hit_en3 ? periph_irq_enable_three :
      hit_ctl ? ctrl :
      hit_sts ? irq_stat :
      hit_msk ? irq_mask :
      hit_pnd ? pend_view : `REG_RESET;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addr_ok;
      prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      periph_irq_enable_one   <= `REG_RESET;
      periph_irq_enable_two   <= `REG_RESET;
      periph_irq_enable_three <= `REG_RESET;
    end else if (wr_take) begin
      if (hit_en1)
        periph_irq_enable_one <= wmerge(periph_irq_enable_one, wbyte,
                                        `EN_ONE_WMASK);
      if (hit_en2)
        periph_irq_enable_two <= wmerge(periph_irq_enable_two, wbyte,
                                        `EN_TWO_WMASK);
      if (hit_en3)
        periph_irq_enable_three <= wmerge(periph_irq_enable_three, wbyte,
                                          `EN_THREE_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl     <= `REG_RESET;
      irq_mask <= `REG_RESET;
    end else if (wr_take) begin
      if (hit_ctl)
        ctrl <= wmerge(ctrl, ctrl_wdata, `CTRL_WMASK);
      if (hit_msk)
        irq_mask <= wmerge(irq_mask, wbyte, `STAT_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat       <= `REG_RESET;
      prev_flags     <= `REG_RESET;
      cpu_periph_req <= 1'b0;
      irq            <= 1'b0;
    end else begin
      irq_stat       <= next_stat;
      prev_flags     <= fb.flags;
      cpu_periph_req <= next_req;
      irq            <= |(irq_stat & irq_mask);
    end
  end

  property p_en_write;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_take && hit_en1 |=> periph_irq_enable_one == $past(wbyte);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable 1 not stored");

  property p_gate_off;
    @(posedge ref_clk) disable iff (sys_rst)
    !prio_en && !global_periph_irq_enable |=> !cpu_periph_req;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request not gated");

  property p_en_one_map;
    @(posedge ref_clk) disable iff (sys_rst)
    periph_flags_one[7] && periph_irq_enable_one[7] && global_periph_irq_enable
      |=> cpu_periph_req;
  endproperty
  a_en_one_map: assert property (p_en_one_map) else $error("bit 7 no req");

  property p_en_two_gap;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_take && hit_en2 |=> periph_irq_enable_two[6:4] == 3'b000;
  endproperty
  a_en_two_gap: assert property (p_en_two_gap) else $error("en2 gap set");

  property p_en_three_ro;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_take && hit_en3 |=> (periph_irq_enable_three & 8'hf1) == 8'h00
      && periph_irq_enable_three[3:1] == $past(wbyte[3:1]);
  endproperty
  a_en_three_ro: assert property (p_en_three_ro) else $error("en3 bad");

  property p_reset_zero;
    @(posedge ref_clk)
    sys_rst |=> ctrl == 8'h00 && irq_stat == 8'h00 && !cpu_periph_req
      && periph_irq_enable_two == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");

  property p_req_cause;
    @(posedge ref_clk) disable iff (sys_rst)
    !any_pend |=> !cpu_periph_req;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("req w/o cause");

  property p_irq_level;
    @(posedge ref_clk) disable iff (sys_rst)
    (|(irq_stat & irq_mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing");

  property p_apb_ack;
    @(posedge ref_clk) disable iff (sys_rst)
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_ack: assert property (p_apb_ack) else $error("apb ack timing");
endmodule
`default_nettype wire

// *** src/pirq_map.svh ***
// Offsets, field positions, masks and reset values of the interrupt block
`ifndef PIRQ_MAP_SVH
`define PIRQ_MAP_SVH
`define OFS_CAN_FLAGS    8'h00
`define OFS_EN_ONE       8'h04
`define OFS_EN_TWO       8'h08
`define OFS_EN_THREE     8'h0c
`define OFS_CTRL         8'h10
`define OFS_IRQ_STAT     8'h14
`define OFS_IRQ_MASK     8'h18
`define OFS_PEND         8'h1c
`define CAN_BAD_MSG_BIT  7
`define CAN_WAKE_BIT     6
`define CAN_ERROR_BIT    5
`define CAN_TX2_BIT      4
`define CAN_TX1_BIT      3
`define CAN_TX0_BIT      2
`define CAN_RX1_BIT      1
`define CAN_RX0_BIT      0
`define CTRL_PRIO_BIT    0
`define CTRL_GLOBAL_PERIPH_IRQ_ENABLE_BIT    1
`define CTRL_MODE_LSB    2
`define CTRL_HF_BIT      4
`define CTRL_WMASK       8'h1f
`define EN_ONE_WMASK     8'hff
`define EN_TWO_WMASK     8'h8f
`define EN_THREE_WMASK   8'h0e
`define STAT_CAN_BIT     0
`define STAT_REQ_BIT     1
`define STAT_WMASK       8'h03
`define REG_RESET        8'h00
`define FLAGS_MODE1_KEEP 8'hfe
`define FLAGS_ALL_KEEP   8'hff
`endif

// *** src/pirq_pkg.sv ***
// Types shared by the peripheral interrupt block
package pirq_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    CAN_MODE_LEGACY   = 2'b00,
    CAN_MODE_ENHANCED = 2'b01,
    CAN_MODE_FIFO     = 2'b10
  } can_mode_e;
endpackage

// *** src/pirq_if.sv ***
// Signals between the register side and the CAN flag bank
`timescale 1ns/1ps
`default_nettype none
interface pirq_if;
  import pirq_pkg::*;
  logic      clk;
  logic      rst;
  can_mode_e mode;
  logic      hf_sel;
  logic      ev_bad_msg;
  logic      ev_wake;
  byte_t     comm_status;
  logic [2:0] ev_tx_done;
  logic      ev_rx0;
  logic      ev_rx1;
  logic      ev_rx_any;
  logic      fifo_half_lvl;
  logic      fifo_full_lvl;
  logic      wr_en;
  byte_t     wr_data;
  byte_t     flags;
  modport bank (input clk, rst, mode, hf_sel, ev_bad_msg, ev_wake,
                input comm_status, ev_tx_done, ev_rx0, ev_rx1, ev_rx_any,
                input fifo_half_lvl, fifo_full_lvl, wr_en, wr_data,
                output flags);
  modport owner (output clk, rst, mode, hf_sel, ev_bad_msg, ev_wake,
                 output comm_status, ev_tx_done, ev_rx0, ev_rx1, ev_rx_any,
                 output fifo_half_lvl, fifo_full_lvl, wr_en, wr_data,
                 input flags);
endinterface
`default_nettype wire

// *** src/can_flag_bank.sv ***
// CAN event flag register with mode-dependent low bits
`timescale 1ns/1ps
`default_nettype none
`include "pirq_map.svh"
module can_flag_bank (
  // Flag bank link
  pirq_if.bank fb
);
  import pirq_pkg::*;

  byte_t prev_comm;
  logic  prev_lvl;
  byte_t next_flags;
  byte_t flags;

  wire       sel_lvl  = fb.hf_sel ? fb.fifo_half_lvl : fb.fifo_full_lvl;
  wire       lvl_rise = sel_lvl && !prev_lvl;
  wire       err_rise = |(fb.comm_status & ~prev_comm);
  wire       legacy   = (fb.mode == CAN_MODE_LEGACY);
  wire       fifo_md  = (fb.mode == CAN_MODE_FIFO);
  // Mode 1 has no bit 0: it neither stores nor reads back
  wire byte_t keep = (fb.mode == CAN_MODE_ENHANCED) ?
                     `FLAGS_MODE1_KEEP : `FLAGS_ALL_KEEP;
  wire byte_t set_vec = {fb.ev_bad_msg,
                         fb.ev_wake,
                         err_rise,
                         fb.ev_tx_done[2], fb.ev_tx_done[1],
                         fb.ev_tx_done[0],
                         legacy ? fb.ev_rx1 : fb.ev_rx_any,
                         legacy ? fb.ev_rx0 :
                         (fifo_md & lvl_rise)};

  // Set wins over a software clear in the same cycle
  assign next_flags = ((fb.wr_en ? fb.wr_data : flags) | set_vec) & keep;
  assign fb.flags   = flags;

  always_ff @(posedge fb.clk) begin
    if (fb.rst) begin
      flags     <= `REG_RESET;
      prev_comm <= `REG_RESET;
      prev_lvl  <= 1'b0;
    end else begin
      flags     <= next_flags;
      prev_comm <= fb.comm_status;
      prev_lvl  <= sel_lvl;
    end
  end

  property p_bad_msg;
    @(posedge fb.clk) disable iff (fb.rst)
    fb.ev_bad_msg |=> flags[`CAN_BAD_MSG_BIT];
  endproperty
  a_bad_msg: assert property (p_bad_msg) else $error("bad msg flag lost");

  property p_wake;
    @(posedge fb.clk) disable iff (fb.rst)
    fb.ev_wake |=> flags[`CAN_WAKE_BIT];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag lost");

  property p_error;
    @(posedge fb.clk) disable iff (fb.rst)
    (|(fb.comm_status & ~$past(fb.comm_status))) && !$past(fb.rst)
      |=> flags[`CAN_ERROR_BIT];
  endproperty
  a_error: assert property (p_error) else $error("error flag lost");

  property p_tx2;
    @(posedge fb.clk) disable iff (fb.rst)
    fb.ev_tx_done[2] |=> flags[`CAN_TX2_BIT];
  endproperty
  a_tx2: assert property (p_tx2) else $error("tx2 done flag lost");

  property p_rx1_legacy;
    @(posedge fb.clk) disable iff (fb.rst)
    legacy && fb.ev_rx1 |=> flags[`CAN_RX1_BIT];
  endproperty
  a_rx1_legacy: assert property (p_rx1_legacy) else $error("rx1 lost");

  property p_rx_any;
    @(posedge fb.clk) disable iff (fb.rst)
    !legacy && fb.ev_rx_any |=> flags[`CAN_RX1_BIT];
  endproperty
  a_rx_any: assert property (p_rx_any) else $error("rx any lost");

  property p_mode1_bit0;
    @(posedge fb.clk) disable iff (fb.rst)
    fb.mode == CAN_MODE_ENHANCED |=> !flags[`CAN_RX0_BIT];
  endproperty
  a_mode1_bit0: assert property (p_mode1_bit0) else $error("bit0 set");

  property p_fifo_full;
    @(posedge fb.clk) disable iff (fb.rst)
    fifo_md && lvl_rise |=> flags[`CAN_RX0_BIT];
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("fifo flag lost");
endmodule
`default_nettype wire

// *** dv/can_event_src.sv ***
// CAN controller stand-in that turns bench commands into event pulses
`timescale 1ns/1ps
`default_nettype none
module can_event_src (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Bench commands: [8] any rx, [7:0] one per flag bit
  input  wire logic [8:0] fire,
  // Events toward the block
  output logic            bad_msg,
  output logic            wake,
  output logic [2:0]      tx_done,
  output logic            rx0,
  output logic            rx1,
  output logic            rx_any,
  output pirq_pkg::byte_t status
);
  // Pulses last one cycle; a status bit drops back so each use is a new rise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {bad_msg, wake, tx_done, rx0, rx1, rx_any} <= '0;
      status <= 8'h00;
    end else begin
      bad_msg <= fire[7];
      wake    <= fire[6];
      status  <= {7'h00, fire[5]};
      tx_done <= fire[4:2];
      rx1     <= fire[1];
      rx0     <= fire[0];
      rx_any  <= fire[8];
    end
  end
endmodule
`default_nettype wire

// *** dv/peripheral_irq_flag_enable_bench.sv ***
// Self-checking bench for the peripheral interrupt flag and enable block
`timescale 1ns/1ps
`default_nettype none
`include "pirq_map.svh"
module peripheral_irq_flag_enable_bench;
  import pirq_pkg::*;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        cpu_periph_req, irq, bad_msg, wake, rx0, rx1, rx_any;
  logic        half_lvl, full_lvl;
  logic [2:0]  tx_done;
  logic [3:0]  pstrb;
  logic [7:0]  paddr;
  logic [8:0]  fire;
  logic [31:0] pwdata, prdata;
  byte_t       status, pf1, pf2, pf3, en_five;
  int          err_total, num_checks;

  can_event_src i_can_event_src (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .fire(fire), .bad_msg(bad_msg),
    .wake(wake), .tx_done(tx_done), .rx0(rx0), .rx1(rx1), .rx_any(rx_any),
    .status(status));
  periph_irq_top i_periph_irq_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_bad_msg_ev(bad_msg), .can_wake_ev(wake), .can_comm_status(status),
    .can_tx_done_ev(tx_done), .can_rx0_ev(rx0), .can_rx1_ev(rx1),
    .can_rx_any_ev(rx_any), .can_fifo_half_lvl(half_lvl),
    .can_fifo_full_lvl(full_lvl), .periph_flags_one(pf1),
    .periph_flags_two(pf2), .periph_flags_three(pf3),
    .can_enable_five(en_five), .cpu_periph_req(cpu_periph_req), .irq(irq));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string w, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input byte_t d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge ref_clk);
    if (n >= 50) begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input byte_t d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string w, input logic [7:0] a, input byte_t x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(w, {24'h0, x}, r);
  endtask

  task automatic fire_ev(input logic [8:0] f);
    fire <= f;
    @(posedge ref_clk);
    fire <= 9'h000;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd_chk("reset value", 8'(i * 4), 8'h00);
  endtask

  task automatic t_enables();
    logic [7:0] a[3] = '{`OFS_EN_ONE, `OFS_EN_TWO, `OFS_EN_THREE};
    byte_t      m[3] = '{8'hff, 8'h8f, 8'h0e};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], 8'hff);
      rd_chk("enable set", a[i], m[i]);
      wr(a[i], 8'h00);
      rd_chk("enable clear", a[i], 8'h00);
    end
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h20, 8'h00, r, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
  endtask

  // Mode 0: each event sets exactly its own bit
  task automatic t_mode0();
    for (int b = 7; b >= 0; b--) begin
      fire_ev(9'h001 << b);
      rd_chk("mode0 flag", `OFS_CAN_FLAGS, 8'h01 << b);
      wr(`OFS_CAN_FLAGS, 8'h00);
    end
  endtask

  task automatic t_mode1();
    wr(`OFS_CTRL, 8'h04);
    fire_ev(9'h100);
    rd_chk("mode1 any rx", `OFS_CAN_FLAGS, 8'h02);
    wr(`OFS_CAN_FLAGS, 8'h00);
    fire_ev(9'h001);
    rd_chk("mode1 bit0", `OFS_CAN_FLAGS, 8'h00);
    wr(`OFS_CAN_FLAGS, 8'hff);
    rd_chk("mode1 write", `OFS_CAN_FLAGS, 8'hfe);
    wr(`OFS_CAN_FLAGS, 8'h00);
  endtask

  // Mode 2: only the level chosen by the select bit sets bit 0
  task automatic t_mode2();
    wr(`OFS_CTRL, 8'h08);
    half_lvl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("fifo half ignored", `OFS_CAN_FLAGS, 8'h00);
    full_lvl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("fifo full", `OFS_CAN_FLAGS, 8'h01);
    half_lvl <= 1'b0;
    full_lvl <= 1'b0;
    wr(`OFS_CAN_FLAGS, 8'h00);
    fire_ev(9'h100);
    rd_chk("mode2 any rx", `OFS_CAN_FLAGS, 8'h02);
    wr(`OFS_CAN_FLAGS, 8'h00);
    wr(`OFS_CTRL, 8'h18);
    half_lvl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("fifo half", `OFS_CAN_FLAGS, 8'h01);
    half_lvl <= 1'b0;
    wr(`OFS_CAN_FLAGS, 8'h00);
  endtask

  task automatic t_request();
    wr(`OFS_CTRL, 8'h00);
    en_five <= 8'h40;
    fire_ev(9'h040);
    check("req gated", 32'h0, {31'h0, cpu_periph_req});
    wr(`OFS_CTRL, 8'h02);
    repeat (3) @(posedge ref_clk);
    check("req global", 32'h1, {31'h0, cpu_periph_req});
    wr(`OFS_CTRL, 8'h01);
    repeat (3) @(posedge ref_clk);
    check("req priority", 32'h1, {31'h0, cpu_periph_req});
    en_five <= 8'h00;
    repeat (3) @(posedge ref_clk);
    check("req disabled", 32'h0, {31'h0, cpu_periph_req});
    rd_chk("flag kept", `OFS_CAN_FLAGS, 8'h40);
    wr(`OFS_CAN_FLAGS, 8'h00);
    pf1 <= 8'h01;
    wr(`OFS_EN_ONE, 8'h01);
    repeat (3) @(posedge ref_clk);
    check("req enable one", 32'h1, {31'h0, cpu_periph_req});
    wr(`OFS_EN_ONE, 8'h00);
    repeat (3) @(posedge ref_clk);
    check("req enable off", 32'h0, {31'h0, cpu_periph_req});
    pf1 <= 8'h00;
  endtask

  task automatic t_irq();
    wr(`OFS_IRQ_MASK, 8'h01);
    wr(`OFS_IRQ_STAT, 8'h03);
    fire_ev(9'h080);
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk("irq status", `OFS_IRQ_STAT, 8'h01);
    wr(`OFS_IRQ_STAT, 8'h01);
    wr(`OFS_CAN_FLAGS, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_MASK, 8'h00);
    fire_ev(9'h080);
    check("irq masked", 32'h0, {31'h0, irq});
    rd_chk("masked status", `OFS_IRQ_STAT, 8'h01);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, half_lvl, full_lvl} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    fire = 9'h000;
    {pf1, pf2, pf3, en_five} = '0;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_enables();
    t_unmapped();
    t_mode0();
    t_mode1();
    t_mode2();
    t_request();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
